// File: logic/mtc_pkg.sv
// Purpose: shared constants and carriers for the quarter frame time code block
// Assumes: one 25 MHz clock; byte serialisation is done elsewhere
// Notes: time fields are binary, not bcd
package mtc_pkg;
	// status byte that opens every quarter frame message
	localparam logic [7:0] QF_STATUS = 8'hF1;
	// first real-time status byte; these may interleave and are skipped
	localparam logic [7:0] REALTIME_FIRST = 8'hF8;
	localparam logic [2:0] TYPE_FIRST = 3'h0;
	localparam logic [2:0] TYPE_LAST = 3'h7;
	localparam logic [7:0] ALL_TYPES = 8'hFF;
	// time code type codes carried in the hours byte
	localparam logic [1:0] RATE_24 = 2'h0;
	localparam logic [1:0] RATE_25 = 2'h1;
	localparam logic [1:0] RATE_30_DROP = 2'h2;
	localparam logic [1:0] RATE_30 = 2'h3;
	// timing
	localparam int MCLK_HZ = 25_000_000;
	localparam int QF_PER_FRAME = 4;
	localparam int FPS_24 = 24;
	localparam int FPS_25 = 25;
	localparam int FPS_30 = 30;
	// quarter frame interval in clock cycles, rounded down
	localparam int QF_CYC_24 = MCLK_HZ / (FPS_24 * QF_PER_FRAME);
	localparam int QF_CYC_25 = MCLK_HZ / (FPS_25 * QF_PER_FRAME);
	localparam int QF_CYC_30 = MCLK_HZ / (FPS_30 * QF_PER_FRAME);
	localparam int CNT_W = 24;

	typedef struct packed {
		logic [1:0] rate;
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [4:0] frames;
	} smpte_time_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} stream_byte_s;

	typedef struct packed {
		logic tick;
		logic reverse;
		logic [2:0] msg_type;
		logic [3:0] nibble;
	} qf_event_s;

	typedef enum logic [2:0] {
		GEN_IDLE = 3'b001,
		GEN_STATUS = 3'b010,
		GEN_DATA = 3'b100
	} gen_state_e;
endpackage

// File: logic/midi_time_code_quarter_frame.sv
// Purpose: quarter frame time code generator and receiver on a byte stream
// Assumes: bytes in and out are on the mclk domain, no synchroniser needed
// Notes: full messages, user bits and set up are handled elsewhere
// What this block does
// - generator starts quarter frames only while run is high
// - one message per quarter frame: 120 per second at 30 fps
// - eight messages form a group carrying the whole time
// - each message is two bytes, status byte F1 first
// - second byte holds message number 0..7 and a data nibble
// - receiver pulses a tick on every quarter frame received
// - time is hours, minutes, seconds and frame number
// - only quarter frames handled; user bits not supported
// - receiver exposes cycles since tick and last tick gap
// - second byte is 0, three-bit type, four data bits
// - forward sends types 0 to 7, reverse sends 7 to 0
// - hours byte bits 5 and 6 carry the time code type
`timescale 1ns/100ps
module midi_time_code_quarter_frame #(
	parameter int QF_CYC_24 = mtc_pkg::QF_CYC_24,
	parameter int QF_CYC_25 = mtc_pkg::QF_CYC_25,
	parameter int QF_CYC_30 = mtc_pkg::QF_CYC_30
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic gen_run,
	input wire logic gen_reverse,
	input mtc_pkg::smpte_time_s gen_time,
	output mtc_pkg::stream_byte_s tx_byte,
	input wire logic tx_ready,
	input mtc_pkg::stream_byte_s rx_byte,
	output mtc_pkg::qf_event_s rx_event,
	output mtc_pkg::smpte_time_s rx_time,
	output logic rx_time_valid,
	output logic [mtc_pkg::CNT_W-1:0] rx_since_tick,
	output logic [mtc_pkg::CNT_W-1:0] rx_tick_gap
);
	// nibble k of the time, low nibble of frames first
	function automatic logic [3:0] qf_nibble(input mtc_pkg::smpte_time_s t,
		input logic [2:0] k);
		logic [31:0] w;
		w = {1'b0, t.rate, t.hours, 2'b00, t.minutes, 2'b00, t.seconds,
			3'b000, t.frames};
		return w[{k, 2'b00} +: 4];
	endfunction

	// next type in the running direction
	function automatic logic [2:0] step_type(input logic [2:0] k,
		input logic rev);
		return rev ? k - 3'h1 : k + 3'h1;
	endfunction

	localparam logic [mtc_pkg::CNT_W-1:0] P24 = mtc_pkg::CNT_W'(QF_CYC_24 - 1);
	localparam logic [mtc_pkg::CNT_W-1:0] P25 = mtc_pkg::CNT_W'(QF_CYC_25 - 1);
	localparam logic [mtc_pkg::CNT_W-1:0] P30 = mtc_pkg::CNT_W'(QF_CYC_30 - 1);
	localparam logic [mtc_pkg::CNT_W-1:0] CNT_MAX = '1;

	mtc_pkg::gen_state_e state_r;
	logic [mtc_pkg::CNT_W-1:0] qf_cnt_r;
	logic [mtc_pkg::CNT_W-1:0] qf_last;
	logic [2:0] gen_type_r;
	mtc_pkg::smpte_time_s snap_r;
	logic qf_due;
	logic group_start;

	// quarter frame interval follows the time code type on gen_time, not the sampled one being sent
	always_comb begin
		case (gen_time.rate)
			mtc_pkg::RATE_24: qf_last = P24;
			mtc_pkg::RATE_25: qf_last = P25;
			default: qf_last = P30;
		endcase
	end

	// first message leaves on the first running cycle, then one per interval
	assign qf_due = gen_run && (qf_cnt_r == '0);
	assign group_start = gen_type_r ==
		(gen_reverse ? mtc_pkg::TYPE_LAST : mtc_pkg::TYPE_FIRST);

	// quarter frame interval counter, held at zero while stopped
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			qf_cnt_r <= '0;
		end else if (clk_en) begin
			if (!gen_run) begin
				qf_cnt_r <= '0;
			end else if (qf_cnt_r >= qf_last) begin
				qf_cnt_r <= '0;
			end else begin
				qf_cnt_r <= qf_cnt_r + 1'b1;
			end
		end
	end

	// message sequencer; a message already begun is always finished so the
	// far end never sees a lone status byte, at the cost of a late stop
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= mtc_pkg::GEN_IDLE;
		end else if (clk_en) begin
			case (state_r)
				mtc_pkg::GEN_IDLE: begin
					if (qf_due) begin
						state_r <= mtc_pkg::GEN_STATUS;
					end
				end
				mtc_pkg::GEN_STATUS: begin
					if (tx_ready) begin
						state_r <= mtc_pkg::GEN_DATA;
					end
				end
				mtc_pkg::GEN_DATA: begin
					if (tx_ready) begin
						state_r <= mtc_pkg::GEN_IDLE;
					end
				end
				default: state_r <= mtc_pkg::GEN_IDLE;
			endcase
		end
	end

	// message type walks the group; parked at the start point while stopped
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			gen_type_r <= mtc_pkg::TYPE_FIRST;
		end else if (clk_en) begin
			if (state_r == mtc_pkg::GEN_DATA) begin
				if (tx_ready) begin
					gen_type_r <= step_type(gen_type_r, gen_reverse);
				end
			end else if (!gen_run && state_r == mtc_pkg::GEN_IDLE) begin
				gen_type_r <= gen_reverse ? mtc_pkg::TYPE_LAST
					: mtc_pkg::TYPE_FIRST;
			end
		end
	end

	// time is sampled once per group so all eight nibbles agree
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			snap_r <= '0;
		end else if (clk_en) begin
			if (state_r == mtc_pkg::GEN_IDLE && qf_due && group_start) begin
				snap_r <= gen_time;
			end
		end
	end

	// outgoing byte register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_byte <= '0;
		end else if (clk_en) begin
			case (state_r)
				mtc_pkg::GEN_IDLE: begin
					if (qf_due) begin
						tx_byte <= {1'b1, mtc_pkg::QF_STATUS};
					end
				end
				mtc_pkg::GEN_STATUS: begin
					if (tx_ready) begin
						tx_byte <= {1'b1, 1'b0, gen_type_r,
							qf_nibble(snap_r, gen_type_r)};
					end
				end
				mtc_pkg::GEN_DATA: begin
					if (tx_ready) begin
						tx_byte <= '0;
					end
				end
				default: tx_byte <= '0;
			endcase
		end
	end

	// receive side
	logic armed_r;
	logic [31:0] shadow_r;
	logic [7:0] seen_r;
	logic [2:0] rx_last_r;
	logic rx_rev_r;
	logic qf_rx;
	logic [2:0] rx_type;
	logic [7:0] type_bit;
	logic in_fwd;
	logic in_rev;
	logic chained;
	logic [7:0] seen_nxt;
	logic [31:0] shadow_nxt;
	logic group_done;

	assign qf_rx = rx_byte.valid && armed_r && !rx_byte.data[7];
	assign rx_type = rx_byte.data[6:4];
	assign type_bit = 8'h01 << rx_type;
	assign in_fwd = rx_type == step_type(rx_last_r, 1'b0);
	assign in_rev = rx_type == step_type(rx_last_r, 1'b1);
	assign chained = seen_r == '0 || in_fwd || in_rev;
	assign seen_nxt = chained ? (seen_r | type_bit) : type_bit;
	// a group ends at type 7 going forward or type 0 going backward
	assign group_done = seen_nxt == mtc_pkg::ALL_TYPES &&
		((in_fwd && rx_type == mtc_pkg::TYPE_LAST) ||
		(in_rev && rx_type == mtc_pkg::TYPE_FIRST));

	// merge the arriving nibble into the shadow word
	always_comb begin
		shadow_nxt = shadow_r;
		shadow_nxt[{rx_type, 2'b00} +: 4] = rx_byte.data[3:0];
	end

	// status parser; real-time bytes may sit between the two bytes, any
	// other status byte abandons the message, and so does any data byte
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			armed_r <= 1'b0;
		end else if (clk_en && rx_byte.valid) begin
			if (rx_byte.data == mtc_pkg::QF_STATUS) begin
				armed_r <= 1'b1;
			end else if (!rx_byte.data[7] ||
				rx_byte.data < mtc_pkg::REALTIME_FIRST) begin
				armed_r <= 1'b0;
			end
		end
	end

	// group collection and direction tracking
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shadow_r <= '0;
			seen_r <= '0;
			rx_last_r <= mtc_pkg::TYPE_FIRST;
			rx_rev_r <= 1'b0;
		end else if (clk_en && qf_rx) begin
			shadow_r <= shadow_nxt;
			seen_r <= group_done ? 8'h00 : seen_nxt;
			rx_last_r <= rx_type;
			if (in_rev && !in_fwd) begin
				rx_rev_r <= 1'b1;
			end else if (in_fwd) begin
				rx_rev_r <= 1'b0;
			end
		end
	end

	// assembled time changes only when a whole group is in; reserved bits
	// are dropped here so a sender that sets them cannot corrupt the fields
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_time <= '0;
			rx_time_valid <= 1'b0;
		end else if (clk_en && qf_rx && group_done) begin
			rx_time.rate <= shadow_nxt[30:29];
			rx_time.hours <= shadow_nxt[28:24];
			rx_time.minutes <= shadow_nxt[21:16];
			rx_time.seconds <= shadow_nxt[13:8];
			rx_time.frames <= shadow_nxt[4:0];
			rx_time_valid <= 1'b1;
		end
	end

	// one-cycle tick per quarter frame with the nibble it carried
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_event <= '0;
		end else if (clk_en) begin
			rx_event.tick <= qf_rx;
			if (qf_rx) begin
				rx_event.msg_type <= rx_type;
				rx_event.nibble <= rx_byte.data[3:0];
				rx_event.reverse <= in_rev && !in_fwd;
			end
		end
	end

	// tick spacing for interpolation; counters saturate so a stopped link
	// reads as a very long gap instead of wrapping to a small one
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_since_tick <= '0;
			rx_tick_gap <= '0;
		end else if (clk_en) begin
			if (qf_rx) begin
				rx_tick_gap <= rx_since_tick;
				rx_since_tick <= '0;
			end else if (rx_since_tick != CNT_MAX) begin
				rx_since_tick <= rx_since_tick + 1'b1;
			end
		end
	end
endmodule

// File: verif/mtc_monitor.sv
// Purpose: port checker for the quarter frame block
// Assumes: one clock, async active low reset
// Notes: bound to the block at the foot of this file
`timescale 1ns/100ps
module mtc_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic gen_run,
	input mtc_pkg::stream_byte_s tx_byte,
	input wire logic tx_ready,
	input mtc_pkg::stream_byte_s rx_byte,
	input mtc_pkg::qf_event_s rx_event,
	input mtc_pkg::smpte_time_s rx_time,
	input wire logic [mtc_pkg::CNT_W-1:0] rx_since_tick,
	input wire logic [mtc_pkg::CNT_W-1:0] rx_tick_gap
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// outgoing framing: status, one data byte, then quiet
	chk_stop_quiet: assert property (
		!gen_run && !tx_byte.valid |=> !tx_byte.valid)
		else $error("message opened while stopped");
	chk_status_first: assert property (
		$rose(tx_byte.valid) |-> tx_byte.data == mtc_pkg::QF_STATUS)
		else $error("message did not open with status");
	chk_data_next: assert property (
		clk_en && tx_ready && tx_byte.valid &&
		tx_byte.data == mtc_pkg::QF_STATUS |=>
		tx_byte.valid && !tx_byte.data[7])
		else $error("no data byte after status");
	chk_two_bytes: assert property (
		clk_en && tx_ready && tx_byte.valid && !tx_byte.data[7] |=>
		!tx_byte.valid)
		else $error("message longer than two bytes");
	// receive side: tick, counters and atomic time
	chk_tick_seen: assert property (
		clk_en && rx_byte.valid && rx_byte.data == mtc_pkg::QF_STATUS ##1
		clk_en && rx_byte.valid && !rx_byte.data[7] |=>
		rx_event.tick && rx_event[6:0] == $past(rx_byte.data[6:0]))
		else $error("quarter frame not reported");
	chk_tick_zero: assert property (
		rx_event.tick && $past(clk_en) |->
		rx_since_tick == 0 && rx_tick_gap == $past(rx_since_tick))
		else $error("tick counters wrong");
	chk_count_up: assert property (
		clk_en && !(&rx_since_tick) ##1 !rx_event.tick |->
		rx_since_tick == $past(rx_since_tick) + 1'b1)
		else $error("since tick count stalled");
	chk_time_hold: assert property (
		!rx_event.tick |-> $stable(rx_time))
		else $error("time changed without a tick");
endmodule
bind midi_time_code_quarter_frame mtc_monitor mtc_monitor_inst (
	.mclk(mclk),
	.reset_n(reset_n),
	.clk_en(clk_en),
	.gen_run(gen_run),
	.tx_byte(tx_byte),
	.tx_ready(tx_ready),
	.rx_byte(rx_byte),
	.rx_event(rx_event),
	.rx_time(rx_time),
	.rx_since_tick(rx_since_tick),
	.rx_tick_gap(rx_tick_gap)
);

// File: verif/midi_peer.sv
// Purpose: far midi device sending and taking quarter frames
// Assumes: byte stream on mclk, no reset of its own
// Notes: idle data toggles so a stale byte never looks fresh
`timescale 1ns/100ps
module midi_peer (
	input wire logic mclk,
	input wire logic slow,
	input wire logic send,
	input wire logic bare,
	input wire logic [7:0] qf_byte,
	output logic tx_ready,
	output mtc_pkg::stream_byte_s rx_byte
);
	logic [1:0] stall_r = 2'h0;
	logic pend_r = 1'b0;
	mtc_pkg::stream_byte_s out_r = '0;
	// slow mode is ready one cycle in four to stall the sender
	always_ff @(posedge mclk) stall_r <= stall_r + 2'h1;
	assign tx_ready = !slow || stall_r == 2'h0;
	assign rx_byte = out_r;
	// status then data back to back; bare drops the status on command
	always_ff @(posedge mclk) begin
		if (send) begin
			out_r <= '{1'b1, bare ? qf_byte : mtc_pkg::QF_STATUS};
			pend_r <= !bare;
		end else if (pend_r) begin
			out_r <= '{1'b1, qf_byte};
			pend_r <= 1'b0;
		end else begin
			out_r <= '{1'b0, ~out_r.data};
		end
	end
endmodule

// File: verif/midi_time_code_quarter_frame_bench.sv
// Purpose: self-checking bench for the quarter frame block
// Assumes: intervals shortened to 20/16/12 cycles
// Notes: rows serve both receive and send checks
`timescale 1ns/100ps
module midi_time_code_quarter_frame_bench;
	localparam int N24 = 20;
	localparam int N30 = 12;
	localparam int N25 = 16;
	// same digits as the reverse time, sent at 25 fps
	localparam mtc_pkg::smpte_time_s T_25 = '{2'h1, 5'h17, 6'h3B, 6'h3A,
		5'h1C};
	localparam mtc_pkg::smpte_time_s T_FWD = '{2'h3, 5'h01, 6'h25, 6'h34,
		5'h10};
	localparam mtc_pkg::smpte_time_s T_REV = '{2'h0, 5'h17, 6'h3B, 6'h3A,
		5'h1C};
	typedef struct packed {
		logic [7:0] qf;
		logic [1:0] want;
	} row_s;
	// want is reverse flag then time valid
	row_s rows [16] = '{
		'{8'h00, 2'h0}, '{8'h11, 2'h0}, '{8'h24, 2'h0}, '{8'h33, 2'h0},
		'{8'h45, 2'h0}, '{8'h52, 2'h0}, '{8'h61, 2'h0}, '{8'h76, 2'h1},
		'{8'h71, 2'h1}, '{8'h67, 2'h3}, '{8'h53, 2'h3}, '{8'h4B, 2'h3},
		'{8'h33, 2'h3}, '{8'h2A, 2'h3}, '{8'h11, 2'h3}, '{8'h0C, 2'h3}};
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic gen_run = 1'b0;
	logic gen_reverse = 1'b0;
	logic slow = 1'b0;
	logic send = 1'b0;
	logic bare = 1'b0;
	logic [7:0] qf_byte = 8'h00;
	mtc_pkg::smpte_time_s gen_time = '0;
	mtc_pkg::stream_byte_s tx_byte;
	mtc_pkg::stream_byte_s rx_byte;
	mtc_pkg::qf_event_s rx_event;
	mtc_pkg::smpte_time_s rx_time;
	logic tx_ready;
	logic rx_time_valid;
	logic [23:0] rx_since_tick;
	logic [23:0] rx_tick_gap;
	logic [23:0] t0;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	int last_start = 0;
	midi_time_code_quarter_frame #(.QF_CYC_24(N24), .QF_CYC_25(N25),
		.QF_CYC_30(N30)) midi_time_code_quarter_frame_inst (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.gen_run(gen_run),
		.gen_reverse(gen_reverse),
		.gen_time(gen_time),
		.tx_byte(tx_byte),
		.tx_ready(tx_ready),
		.rx_byte(rx_byte),
		.rx_event(rx_event),
		.rx_time(rx_time),
		.rx_time_valid(rx_time_valid),
		.rx_since_tick(rx_since_tick),
		.rx_tick_gap(rx_tick_gap)
	);
	midi_peer midi_peer_inst (
		.mclk(mclk),
		.slow(slow),
		.send(send),
		.bare(bare),
		.qf_byte(qf_byte),
		.tx_ready(tx_ready),
		.rx_byte(rx_byte)
	);
	initial forever #20 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	task automatic cmp(string n, logic [23:0] e, logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		$display("MISMATCH wait expected done seen timeout");
		conclude();
	endtask
	// peer sends one quarter frame; the tick shows two cycles later
	task automatic rx_qf(logic [7:0] b, logic nb);
		qf_byte = b;
		bare = nb;
		send = 1'b1;
		@(negedge mclk);
		send = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	// wait out a byte until the peer accepts it
	task automatic take();
		int t = 0;
		while (tx_ready !== 1'b1) begin
			if (++t > 50) hang();
			@(negedge mclk);
		end
		@(negedge mclk);
	endtask
	task automatic gen_qf(logic [7:0] e, int n);
		int t = 0;
		while (tx_byte.valid !== 1'b1) begin
			if (++t > 99) hang();
			@(negedge mclk);
		end
		if (n > 0) cmp("interval", 24'(n), 24'(cyc - last_start));
		last_start = cyc;
		cmp("status", mtc_pkg::QF_STATUS, tx_byte.data);
		take();
		cmp("qf byte", {1'b1, e}, tx_byte);
		take();
		cmp("after", 24'h0, tx_byte.valid);
	endtask
	initial begin
		repeat (8) @(negedge mclk);
		cmp("reset tx", 24'h0, tx_byte);
		reset_n = 1'b1;
		for (int i = 0; i < 16; i++) begin
			rx_qf(rows[i].qf, 1'b0);
			cmp("event", {1'b1, rows[i].want[1], rows[i].qf[6:0]},
				rx_event);
			cmp("valid", rows[i].want[0], rx_time_valid);
			if (i > 0) cmp("gap", 24'h2, rx_tick_gap);
			if (i > 6) cmp("time", i < 15 ? T_FWD : T_REV, rx_time);
		end
		// a frozen block must hold its counters
		clk_en = 1'b0;
		t0 = rx_since_tick;
		repeat (4) @(negedge mclk);
		cmp("frozen", t0, rx_since_tick);
		clk_en = 1'b1;
		t0 = rx_since_tick;
		rx_qf(8'h35, 1'b1);
		cmp("bare byte", t0 + 24'h3, rx_since_tick);
		gen_time = T_FWD;
		gen_run = 1'b1;
		for (int k = 0; k < 8; k++) begin
			gen_qf(rows[k].qf, k > 0 ? N30 : 0);
		end
		gen_run = 1'b0;
		gen_reverse = 1'b1;
		repeat (40) @(negedge mclk);
		cmp("stopped", 24'h0, tx_byte.valid);
		gen_time = T_REV;
		slow = 1'b1;
		gen_run = 1'b1;
		for (int k = 8; k < 16; k++) begin
			gen_qf(rows[k].qf, k > 8 ? N24 : 0);
		end
		// rate change mid run: the interval follows at once, while the
		// time itself is only taken at the next group start
		gen_time = T_25;
		gen_qf(8'h73, N25);
		gen_qf(8'h67, N25);
		conclude();
	end
endmodule
